// ---- hw/memory_space_pkg.sv ----
// Package for the memory space decoder: address map, register offsets,
// request and answer carriers, and strap encodings.
// Assumes a 16-bit core with a 24-bit physical address and an APB register port.
package memory_space_pkg;

    // Physical address map of segment 0.
    localparam logic [15:0] RAM_LO       = 16'hfa00;
    localparam logic [15:0] RAM_HI       = 16'hfdff;
    localparam logic [15:0] SFR_LO       = 16'hfe00;
    localparam logic [15:0] SFR_HI       = 16'hffff;
    localparam logic [15:0] XREG_LO      = 16'hf000;
    localparam logic [15:0] XREG_HI      = 16'hf1ff;
    localparam logic [15:0] PEC_PTR_LO   = 16'hfce0;
    localparam logic [15:0] BIT_RAM_BASE = 16'hfd00;
    localparam logic [15:0] SFR_BIT_BASE = 16'hff00;
    localparam logic [15:0] XREG_BIT_BASE = 16'hf100;
    localparam logic [7:0]  SEG_ZERO     = 8'h00;
    localparam logic [7:0]  SHORT_GPR    = 8'hf0;
    localparam logic [7:0]  BIT_SFR_FIRST = 8'h80;
    localparam logic [9:0]  SFR_OFF_MASK = 10'h1ff;

    // APB register byte offsets.
    localparam logic [7:0] OFF_CONTEXT  = 8'h00;
    localparam logic [7:0] OFF_PAGE0    = 8'h04;
    localparam logic [7:0] OFF_CONFIG   = 8'h14;
    localparam logic [7:0] OFF_SWITCH   = 8'h18;

    // Reset values.
    localparam logic [15:0] CONTEXT_RESET = 16'hfc00;
    localparam logic [2:0]  SWITCH_RESET  = 3'h0;

    // Strap pin positions on the multiplexed port.
    localparam int STRAP_BUS_LSB = 6;
    localparam int STRAP_SEG_LSB = 9;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // Upper address masks per segment mode.
    localparam logic [7:0] UPPER_MASK_2 = 8'h03;
    localparam logic [7:0] UPPER_MASK_4 = 8'h0f;
    localparam logic [7:0] UPPER_MASK_8 = 8'hff;

    typedef enum logic [1:0] {BUS_MUX16, BUS_MUX8, BUS_DEMUX16, BUS_DEMUX8} bus_type_t;
    typedef enum logic [1:0] {SEG_NONE, SEG_2BIT, SEG_4BIT, SEG_8BIT} seg_mode_t;
    typedef enum logic [2:0] {
        MODE_LONG, MODE_INDIRECT, MODE_SHORT8, MODE_SHORT4, MODE_BIT, MODE_PEC, MODE_PEC_FETCH
    } addr_mode_t;

    // One core or event-transfer access.
    typedef struct packed {
        logic        valid;
        addr_mode_t  mode;
        logic        write;
        logic        size_byte;
        logic [15:0] addr;
        logic [15:0] wdata;
    } access_req_t;

    // Answer, one cycle after the request.
    typedef struct packed {
        logic        done;
        logic        err;
        logic [3:0]  region;
        logic [23:0] phys_addr;
        logic [15:0] rdata;
        logic [15:0] aux;
    } access_resp_t;

    // Forwarded access to a register area.
    typedef struct packed {
        logic        valid;
        logic        extended;
        logic [8:0]  offset;
        logic        write;
        logic [15:0] wdata;
        logic        bit_en;
        logic [3:0]  bit_pos;
    } area_req_t;

    // Forwarded access to the external bus controller.
    typedef struct packed {
        logic        valid;
        logic [15:0] addr_low;
        logic [7:0]  addr_upper;
        logic        write;
        logic        size_byte;
        logic [15:0] wdata;
    } ext_req_t;

endpackage : memory_space_pkg

// ---- hw/memory_space_decoder.sv ----
// Memory space decoder: translates core and event-transfer accesses into
// internal RAM, standard or extended register area, or external bus traffic.
// Assumes one clock pclk, requests from logic on that clock, straps from pins.
`timescale 1ns/1ps
module memory_space_decoder
    import memory_space_pkg::*;
#(
    parameter int RAM_WORDS  = 512,
    parameter int PAGE_COUNT = 4
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    input  wire access_req_t  access_req,
    output access_resp_t      access_resp,
    input  wire logic         switch_load,
    input  wire logic [2:0]   switch_count,
    input  wire logic         instr_retire,
    output area_req_t         area_req,
    output ext_req_t          ext_req,
    input  wire logic         external_access_pin_n,
    input  wire logic [15:0]  multiplexed_bus_port,
    output bus_type_t         bus_type,
    output seg_mode_t         seg_mode,
    output logic              external_fetch
);

    localparam int RAM_IDX_W = $clog2(RAM_WORDS);

    // Storage and control state.
    logic [15:0]       ram_reg [RAM_WORDS];
    logic [15:0]       context_reg;
    logic [9:0]        page_reg [PAGE_COUNT];
    logic [2:0]        switch_reg;
    logic [2:0]        switch_next;
    logic              code_sync1_reg, code_sync2_reg;
    logic [15:0]       port_sync1_reg, port_sync2_reg;
    logic [1:0]        strap_cnt_reg;
    logic              strap_done_reg;
    bus_type_t         bus_type_reg;
    seg_mode_t         seg_mode_reg;
    logic              external_fetch_reg;
    logic              pready_reg;
    logic [31:0]       prdata_reg;
    logic              pslverr_reg;
    access_resp_t      resp_reg;
    area_req_t         area_reg;
    ext_req_t          ext_reg;

    // Outputs straight from flip-flops.
    assign pready         = pready_reg;
    assign prdata         = prdata_reg;
    assign pslverr        = pslverr_reg;
    assign access_resp    = resp_reg;
    assign area_req       = area_reg;
    assign ext_req        = ext_reg;
    assign bus_type       = bus_type_reg;
    assign seg_mode       = seg_mode_reg;
    assign external_fetch = external_fetch_reg;

    // Request field views.
    wire        req_valid  = access_req.valid;
    wire [15:0] req_addr   = access_req.addr;
    wire [7:0]  short_off  = req_addr[7:0];
    wire [3:0]  bit_pos    = req_addr[11:8];
    wire        is_byte    = access_req.size_byte;
    wire        switch_on  = (switch_reg != SWITCH_RESET);

    wire [15:0] gpr_word   = context_reg + {11'h000, short_off[3:0], 1'b0};
    wire [15:0] gpr_byte   = context_reg + {12'h000, short_off[3:0]};
    wire [15:0] gpr_addr   = is_byte ? gpr_byte : gpr_word;

    wire [15:0] short_base = switch_on ? XREG_LO : SFR_LO;
    wire [15:0] short_sfr  = short_base + {7'h00, short_off, 1'b0};
    // register window wins in both areas
    wire        short_gpr  = (short_off >= SHORT_GPR);

    // bit addresses land in upper halves only
    wire [7:0]  bit_rel    = short_off - BIT_SFR_FIRST;
    wire [15:0] bit_sfr    = (switch_on ? XREG_BIT_BASE : SFR_BIT_BASE) + {7'h00, bit_rel, 1'b0};
    wire [15:0] bit_ram    = BIT_RAM_BASE + {7'h00, short_off, 1'b0};
    wire [15:0] bit_addr   = short_gpr ? gpr_word :
                             (short_off < BIT_SFR_FIRST) ? bit_ram : bit_sfr;

    // pointer pair base for a channel
    wire [15:0] pec_pair   = PEC_PTR_LO + {11'h000, req_addr[2:0], 2'b00};

    // page translation for long and indirect modes
    wire [9:0]  page_sel   = page_reg[req_addr[15:14]];
    wire [23:0] paged_addr = {page_sel, req_addr[13:0]};

    // Physical address per addressing mode.
    logic [23:0] phys;
    always_comb begin
        case (access_req.mode)
            MODE_LONG, MODE_INDIRECT: phys = paged_addr;
            MODE_SHORT8:              phys = {SEG_ZERO, short_gpr ? gpr_addr : short_sfr};
            MODE_SHORT4:              phys = {SEG_ZERO, gpr_addr};
            MODE_BIT:                 phys = {SEG_ZERO, bit_addr};
            MODE_PEC:                 phys = {SEG_ZERO, req_addr};
            MODE_PEC_FETCH:           phys = {SEG_ZERO, pec_pair};
            default:                  phys = paged_addr;
        endcase
    end

    // internal areas decode only in segment 0
    wire        seg0     = (phys[23:16] == SEG_ZERO);
    wire [15:0] low16    = phys[15:0];
    wire        hit_ram  = seg0 && (low16 >= RAM_LO) && (low16 <= RAM_HI);
    wire        hit_sfr  = seg0 && (low16 >= SFR_LO);
    wire        hit_xreg = seg0 && (low16 >= XREG_LO) && (low16 <= XREG_HI);
    wire        hit_ext  = !(hit_ram || hit_sfr || hit_xreg);
    wire [3:0]  region   = {hit_ext, hit_xreg, hit_sfr, hit_ram};

    // word accesses need an even address
    wire        odd_word = !is_byte && phys[0] && (access_req.mode != MODE_BIT);
    // no bit access can reach the external bus
    wire        ext_bit  = hit_ext && (access_req.mode == MODE_BIT);
    // short modes never reach external data
    wire        ext_short = hit_ext && ((access_req.mode == MODE_SHORT8) || (access_req.mode == MODE_SHORT4));
    wire        req_err  = odd_word || ext_bit || ext_short;

    // RAM index from the physical address.
    wire [15:0]          ram_off   = low16 - RAM_LO;
    wire [RAM_IDX_W-1:0] ram_idx   = ram_off[RAM_IDX_W:1];
    wire [RAM_IDX_W-1:0] ram_idx2  = ram_idx + RAM_IDX_W'(1);
    wire [15:0]          ram_word  = ram_reg[ram_idx];
    wire [7:0]           ram_sel8  = phys[0] ? ram_word[15:8] : ram_word[7:0];

    // pointer words are plain RAM for byte and word traffic
    wire [15:0] ram_read  = (access_req.mode == MODE_BIT) ? {15'h0000, ram_word[bit_pos]} :
                            is_byte ? {8'h00, ram_sel8} : ram_word;
    wire [7:0]  wbyte     = access_req.wdata[7:0];
    wire [15:0] ram_merge = (access_req.mode == MODE_BIT) ?
                            ((ram_word & ~(16'h0001 << bit_pos)) | ({15'h0000, access_req.wdata[0]} << bit_pos)) :
                            !is_byte ? access_req.wdata :
                            phys[0] ? {wbyte, ram_word[7:0]} : {ram_word[15:8], wbyte};
    wire        ram_we    = req_valid && hit_ram && access_req.write && !req_err
                            && (access_req.mode != MODE_PEC_FETCH);

    // byte writes zero the complementary byte
    wire [15:0] area_wdata = !is_byte ? access_req.wdata :
                             phys[0] ? {wbyte, 8'h00} : {8'h00, wbyte};

    // upper address lines masked by segment mode
    logic [7:0] upper_mask;
    always_comb begin
        case (seg_mode_reg)
            SEG_NONE: upper_mask = 8'h00;
            SEG_2BIT: upper_mask = UPPER_MASK_2;
            SEG_4BIT: upper_mask = UPPER_MASK_4;
            SEG_8BIT: upper_mask = UPPER_MASK_8;
            default:  upper_mask = 8'h00;
        endcase
    end

    // Internal RAM, flip-flop storage written by index.
    always_ff @(posedge pclk) begin
        if (ram_we) begin
            ram_reg[ram_idx] <= ram_merge;
        end
    end

    // source at the lower word, destination above
    wire [15:0] pec_src  = ram_word;
    wire [15:0] pec_dst  = ram_reg[ram_idx2];
    wire        is_fetch = (access_req.mode == MODE_PEC_FETCH);

    // Answer to the requester, one cycle after the request.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp_reg <= '0;
        end else begin
            resp_reg.done      <= req_valid;
            resp_reg.err       <= req_valid && req_err;
            resp_reg.region    <= req_valid ? region : 4'h0;
            resp_reg.phys_addr <= phys;
            resp_reg.rdata     <= is_fetch ? pec_src : (hit_ram ? ram_read : 16'h0000);
            resp_reg.aux       <= is_fetch ? pec_dst : 16'h0000;
        end
    end

    // Forwarding to the register areas.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            area_reg <= '0;
        end else begin
            area_reg.valid    <= req_valid && (hit_sfr || hit_xreg) && !req_err;
            area_reg.extended <= hit_xreg;
            area_reg.offset   <= low16[8:0] & SFR_OFF_MASK[8:0];
            area_reg.write    <= access_req.write;
            area_reg.wdata    <= area_wdata;
            // bit mode flagged toward the area
            area_reg.bit_en   <= (access_req.mode == MODE_BIT);
            area_reg.bit_pos  <= bit_pos;
        end
    end

    // event transfers pass to external segment 0 untranslated
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_reg <= '0;
        end else begin
            ext_reg.valid      <= req_valid && hit_ext && !req_err;
            ext_reg.addr_low   <= low16;
            ext_reg.addr_upper <= phys[23:16] & upper_mask;
            ext_reg.write      <= access_req.write;
            ext_reg.size_byte  <= is_byte;
            ext_reg.wdata      <= access_req.wdata;
        end
    end

    // count down instructions under the switch
    always_comb begin
        switch_next = switch_reg;
        if (switch_load) begin
            switch_next = switch_count;
        end else if (instr_retire && switch_on) begin
            switch_next = switch_reg - 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_reg <= SWITCH_RESET;
        end else begin
            switch_reg <= switch_next;
        end
    end

    // Strap pins pass a two-stage synchroniser.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_sync1_reg <= 1'b1;
            code_sync2_reg <= 1'b1;
            port_sync1_reg <= 16'h0000;
            port_sync2_reg <= 16'h0000;
        end else begin
            code_sync1_reg <= external_access_pin_n;
            code_sync2_reg <= code_sync1_reg;
            port_sync1_reg <= multiplexed_bus_port;
            port_sync2_reg <= port_sync1_reg;
        end
    end

    // latch model and bus type once after release
    wire strap_take = !strap_done_reg && (strap_cnt_reg == STRAP_SETTLE);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_cnt_reg  <= 2'h0;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_cnt_reg  <= strap_cnt_reg + 2'h1;
            strap_done_reg <= strap_take;
        end
    end

    // bus type and segment mode, multiplexed 16-bit until latched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_type_reg       <= BUS_MUX16;
            seg_mode_reg       <= SEG_NONE;
            external_fetch_reg <= 1'b1;
        end else if (strap_take) begin
            bus_type_reg       <= bus_type_t'(port_sync2_reg[STRAP_BUS_LSB +: 2]);
            seg_mode_reg       <= seg_mode_t'(port_sync2_reg[STRAP_SEG_LSB +: 2]);
            external_fetch_reg <= !code_sync2_reg;
        end
    end

    // APB decode.
    wire        apb_access = psel && penable && !pready_reg;
    wire        apb_wr     = apb_access && pwrite;
    wire        sel_ctx    = (paddr == OFF_CONTEXT);
    wire        sel_cfg    = (paddr == OFF_CONFIG);
    wire        sel_sw     = (paddr == OFF_SWITCH);
    wire [7:0]  page_rel   = paddr - OFF_PAGE0;
    wire        sel_page   = (paddr >= OFF_PAGE0) && (page_rel[7:2] < 6'(PAGE_COUNT)) && (paddr[1:0] == 2'b00);
    wire        apb_mapped = sel_ctx || sel_cfg || sel_sw || sel_page;
    // Status words assembled for reads.
    wire [31:0] cfg_word   = {26'h0000000, strap_done_reg, seg_mode_reg, bus_type_reg, external_fetch_reg};
    wire [31:0] page_word  = {22'h000000, page_reg[page_rel[3:2]]};
    wire [31:0] read_word  = sel_ctx ? {16'h0000, context_reg} :
                             sel_page ? page_word :
                             sel_cfg ? cfg_word :
                             sel_sw ? {29'h00000000, switch_reg} : 32'h00000000;

    // bank base set by software, kept word aligned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            context_reg <= CONTEXT_RESET;
        end else if (apb_wr && sel_ctx) begin
            context_reg <= {pwdata[15:1], 1'b0};
        end
    end

    // Page pointers, one per page select.
    for (genvar p = 0; p < PAGE_COUNT; p++) begin : g_page
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                page_reg[p] <= 10'(p);
            end else if (apb_wr && sel_page && (page_rel[3:2] == 2'(p))) begin
                page_reg[p] <= pwdata[9:0];
            end
        end
    end

    // APB answer one cycle into the access phase; unmapped gives an error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= apb_access;
            prdata_reg  <= (apb_access && !pwrite) ? read_word : 32'h00000000;
            pslverr_reg <= apb_access && !apb_mapped;
        end
    end

endmodule : memory_space_decoder

// ---- test/memory_space_sva.sv ----
// Checker for the memory space decoder, watching its access and forward ports.
// Assumes the bind below attaches it to every decoder instance.
`timescale 1ns/1ps
module memory_space_sva
    import memory_space_pkg::*;
(
    input wire logic         pclk,
    input wire logic         presetn,
    input wire access_req_t  access_req,
    input wire access_resp_t access_resp,
    input wire area_req_t    area_req,
    input wire ext_req_t     ext_req,
    input wire seg_mode_t    seg_mode
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Answers, regions and forwards tied to the access that caused them.
    resp_timing_a: assert property (access_req.valid |=> access_resp.done)
        else $error("access answer missing");
    region_onehot_a: assert property (access_resp.done && !access_resp.err |-> $onehot(access_resp.region))
        else $error("region not one-hot");
    err_blocks_a: assert property (access_resp.done && access_resp.err |-> !area_req.valid && !ext_req.valid)
        else $error("refused access forwarded");
    ext_forward_a: assert property (access_resp.done && !access_resp.err && access_resp.region[3] |->
        ext_req.valid && ext_req.addr_low == access_resp.phys_addr[15:0])
        else $error("external access not forwarded");
    ram_range_a: assert property (access_resp.done && access_resp.region == 4'h1 |->
        access_resp.phys_addr inside {[24'h00fa00:24'h00fdff]})
        else $error("ram region outside ram");
    sfr_range_a: assert property (access_resp.done && access_resp.region == 4'h2 |->
        access_resp.phys_addr inside {[24'h00fe00:24'h00ffff]})
        else $error("standard area outside range");
    xreg_range_a: assert property (access_resp.done && access_resp.region == 4'h4 |->
        access_resp.phys_addr inside {[24'h00f000:24'h00f1ff]})
        else $error("extended area outside range");
    upper_mask_a: assert property (ext_req.valid && seg_mode == SEG_2BIT |-> ext_req.addr_upper[7:2] == 6'h00)
        else $error("upper address too wide");
    bit_upper_a: assert property (area_req.valid && area_req.bit_en |-> area_req.offset[8])
        else $error("bit access in lower half");
    pec_direct_a: assert property ($past(access_req.valid && access_req.mode == MODE_PEC) && access_resp.done
        |-> access_resp.phys_addr == {8'h00, $past(access_req.addr)})
        else $error("event transfer address translated");
    // Main scenarios reached.
    ext_seen_c: cover property (ext_req.valid);
    xreg_seen_c: cover property (area_req.valid && area_req.extended);
    err_seen_c: cover property (access_resp.done && access_resp.err);
endmodule : memory_space_sva

bind memory_space_decoder memory_space_sva u_sva (
    .pclk        (pclk),
    .presetn     (presetn),
    .access_req  (access_req),
    .access_resp (access_resp),
    .area_req    (area_req),
    .ext_req     (ext_req),
    .seg_mode    (seg_mode)
);

// ---- test/ext_bus_model.sv ----
// Far side of the decoder: strap pins plus a bus controller that counts forwards.
// Assumes forwarded requests are one-cycle pulses on pclk.
`timescale 1ns/1ps
module ext_bus_model
    import memory_space_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire area_req_t  area_req,
    input  wire ext_req_t   ext_req,
    output logic            external_access_pin_n,
    output logic [15:0]     multiplexed_bus_port,
    output logic [7:0]      ext_count
);
    // straps held steady
    // Straps never move: demultiplexed 16-bit bus, 2-bit segments, external code.
    assign external_access_pin_n = 1'b0;
    assign multiplexed_bus_port  = 16'h0280;
    // Counts accepted external requests; register area requests need no answer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_count <= 8'h00;
        end else if (ext_req.valid) begin
            ext_count <= ext_count + 8'h01;
        end
    end
endmodule : ext_bus_model

// ---- test/tb.sv ----
// Self-checking bench for the memory space decoder.
// Assumes the checker binds itself and the model drives the straps.
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module tb
    import memory_space_pkg::*;
;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic         switch_load, instr_retire, pin_n, er;
    logic [7:0]   paddr, ext_count;
    logic [31:0]  pwdata, prdata, rd;
    logic [2:0]   switch_count;
    logic [15:0]  mbp;
    access_req_t  access_req;
    access_resp_t access_resp, rs;
    area_req_t    area_req, ar;
    ext_req_t     ext_req, xr;
    bus_type_t    bus_type;
    seg_mode_t    seg_mode;
    logic         external_fetch;
    int           failures, tests_run;

    memory_space_decoder #(.RAM_WORDS(512), .PAGE_COUNT(4)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .access_req(access_req), .access_resp(access_resp), .switch_load(switch_load),
        .switch_count(switch_count), .instr_retire(instr_retire), .area_req(area_req),
        .ext_req(ext_req), .external_access_pin_n(pin_n), .multiplexed_bus_port(mbp),
        .bus_type(bus_type), .seg_mode(seg_mode), .external_fetch(external_fetch));
    ext_bus_model u_far (.pclk(pclk), .presetn(presetn), .area_req(area_req), .ext_req(ext_req),
        .external_access_pin_n(pin_n), .multiplexed_bus_port(mbp), .ext_count(ext_count));

    // Free-running 100 MHz clock.
    always #5 pclk = ~pclk;

    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : check

    // One APB transfer; waits for pready and takes data at that edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One access request; captures the answer in the cycle it stands.
    // only data accesses cross areas; no code fetch is issued.
    task automatic acc(input addr_mode_t m, input logic w, input logic b, input logic [15:0] a, input logic [15:0] d);
        @(posedge pclk);
        access_req <= '{1'b1, m, w, b, a, d};
        @(posedge pclk);
        access_req.valid <= 1'b0;
        @(negedge pclk);
        rs = access_resp;
        ar = area_req;
        xr = ext_req;
    endtask : acc

    task automatic retire(input int n);
        repeat (n) begin
            @(posedge pclk);
            instr_retire <= 1'b1;
            @(posedge pclk);
            instr_retire <= 1'b0;
        end
    endtask : retire

    task automatic t_reset();
        apb(1'b0, OFF_CONTEXT, 32'h0);
        `CHK("context reset", CONTEXT_RESET, rd);
        apb(1'b0, OFF_CONFIG, 32'h0);
        `CHK("strap config", 32'h2d, rd);
        `CHK("bus type", BUS_DEMUX16, bus_type);
        `CHK("strap pins", {1'b1, SEG_2BIT}, {external_fetch, seg_mode});
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped error", 1'b1, er);
        acc(MODE_SHORT8, 1'b0, 1'b0, 16'h0020, 16'h0);
        `CHK("short area", 2'b10, {ar.valid, ar.extended});
        $display("test reset finished");
    endtask : t_reset

    task automatic t_gpr();
        acc(MODE_LONG, 1'b1, 1'b0, CONTEXT_RESET + 16'h000a, 16'h1234);
        acc(MODE_SHORT4, 1'b0, 1'b0, 16'h0005, 16'h0);
        `CHK("word reg", 16'h1234, rs.rdata);
        acc(MODE_LONG, 1'b0, 1'b1, CONTEXT_RESET + 16'h000b, 16'h0);
        `CHK("high byte reg", 16'h0012, rs.rdata);
        @(posedge pclk);
        switch_load  <= 1'b1;
        switch_count <= 3'h4;
        @(posedge pclk);
        switch_load  <= 1'b0;
        acc(MODE_SHORT8, 1'b0, 1'b0, 16'h00f5, 16'h0);
        `CHK("reg while switched", 16'h1234, rs.rdata);
        acc(MODE_LONG, 1'b0, 1'b0, 16'hfe20, 16'h0);
        `CHK("long ignores switch", 1'b0, ar.extended);
        retire(3);
        acc(MODE_SHORT8, 1'b0, 1'b0, 16'h0020, 16'h0);
        `CHK("short switched", 1'b1, ar.extended);
        retire(1);
        acc(MODE_SHORT8, 1'b0, 1'b0, 16'h0020, 16'h0);
        `CHK("switch expired", 1'b0, ar.extended);
        $display("test registers finished");
    endtask : t_gpr

    task automatic t_pec();
        acc(MODE_LONG, 1'b1, 1'b0, PEC_PTR_LO + 16'h0008, 16'ha5a5);
        acc(MODE_LONG, 1'b1, 1'b0, PEC_PTR_LO + 16'h000a, 16'h5a5a);
        acc(MODE_PEC_FETCH, 1'b0, 1'b0, 16'h0002, 16'h0);
        `CHK("source pointer", 16'ha5a5, rs.rdata);
        `CHK("dest pointer", 16'h5a5a, rs.aux);
        acc(MODE_LONG, 1'b1, 1'b0, PEC_PTR_LO + 16'h001e, 16'h0000);
        acc(MODE_LONG, 1'b1, 1'b1, PEC_PTR_LO + 16'h001f, 16'h7777);
        acc(MODE_LONG, 1'b0, 1'b0, PEC_PTR_LO + 16'h001e, 16'h0);
        `CHK("unused pointer", 16'h7700, rs.rdata);
        acc(MODE_PEC, 1'b0, 1'b0, 16'h1234, 16'h0);
        `CHK("event external", {4'h8, 24'h001234}, {rs.region, rs.phys_addr});
        $display("test pointers finished");
    endtask : t_pec

    task automatic t_area();
        acc(MODE_LONG, 1'b1, 1'b1, 16'hfe11, 16'habab);
        `CHK("standard offset", {4'h2, 9'h011}, {rs.region, ar.offset});
        `CHK("byte clears other", {1'b1, 16'hab00}, {ar.write, ar.wdata});
        acc(MODE_LONG, 1'b0, 1'b0, 16'hf010, 16'h0);
        `CHK("extended area", {4'h4, 1'b1}, {rs.region, ar.extended});
        acc(MODE_BIT, 1'b1, 1'b0, 16'h0380, 16'h0001);
        `CHK("bit upper half", {1'b1, 4'h3, 9'h100}, {ar.bit_en, ar.bit_pos, ar.offset});
        $display("test areas finished");
    endtask : t_area

    task automatic t_ext();
        logic [7:0] c;
        apb(1'b1, OFF_PAGE0 + 8'h04, 32'h3ff);
        acc(MODE_LONG, 1'b0, 1'b0, 16'h4000, 16'h0);
        `CHK("external region", {4'h8, 2'b10}, {rs.region, xr.valid, xr.write});
        `CHK("segmented address", {8'h03, 16'hc000}, {xr.addr_upper, xr.addr_low});
        @(negedge pclk);
        c = ext_count;
        acc(MODE_LONG, 1'b0, 1'b0, 16'h4001, 16'h0);
        `CHK("odd word refused", 1'b1, rs.err);
        @(negedge pclk);
        `CHK("refused not forwarded", c, ext_count);
        $display("test external finished");
    endtask : t_ext

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    // Reset, then the scenarios in order.
    initial begin
        {failures, tests_run} = '0;
        {pclk, presetn, psel, penable, pwrite, switch_load, instr_retire} = '0;
        {paddr, pwdata, switch_count} = '0;
        access_req = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        t_reset();
        t_gpr();
        t_pec();
        t_area();
        t_ext();
        end_sim();
    end

    // Watchdog well beyond the expected run of under a hundred cycles.
    initial begin
        #20000;
        failures++;
        end_sim();
    end
endmodule : tb
